// File: rtl/mis_pkg.sv
/*
  Shared constants and types for the instruction subset execution block.
  Assumes a single instruction clock; one instruction cycle is one clock cycle.
*/
package mis_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PC_W       = 11;
  localparam int unsigned ADDR_W     = 7;
  localparam int unsigned IMM_W      = 9;
  localparam int unsigned PAGE_W     = 3;
  localparam int unsigned PAGE_LO    = 1;
  localparam int unsigned PAGE_HI    = 2;

  localparam logic [PC_W-1:0]   PC_RESET   = 11'h000;
  localparam logic [PC_W-1:0]   PC_STEP    = 11'h001;
  localparam logic [PC_W-1:0]   PC_SKIP    = 11'h002;
  localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] DEC_STEP   = 8'h01;
  localparam logic              GIE_RESET  = 1'b0;

  localparam logic [3:0]        NIB_MAX    = 4'h9;
  localparam logic [DATA_W:0]   LOW_FIX    = 9'h006;
  localparam logic [DATA_W:0]   HIGH_FIX   = 9'h060;
  localparam logic [DATA_W:0]   BYTE_MAX   = 9'h099;

  typedef enum logic [2:0] {
    OP_NOP      = 3'b000,
    OP_ADD      = 3'b001,
    OP_DEC_ADJ  = 3'b010,
    OP_DEC_SKZ  = 3'b011,
    OP_DIS_INT  = 3'b100,
    OP_ENA_INT  = 3'b101,
    OP_BRANCH   = 3'b110
  } mis_op_type;

  typedef enum logic {
    ST_RUN   = 1'b0,
    ST_FLUSH = 1'b1
  } mis_state_type;

endpackage : mis_pkg

// File: rtl/mis_bcd_if.sv
/*
  Carrier between the execution core and its decimal adjust unit.
  Assumes both ends sit on the same clock; the unit is purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
interface mis_bcd_if;
  logic [7:0] acc;
  logic       carry;
  logic       half;
  logic [7:0] adj;
  logic       carry_adj;

  modport core (output acc, output carry, output half, input adj, input carry_adj);
  modport unit (input acc, input carry, input half, output adj, output carry_adj);
endinterface : mis_bcd_if
`default_nettype wire

// File: rtl/mis_bcd_adj.sv
/*
  Packed decimal correction of an 8-bit binary sum.
  Assumes carry and half carry come from the addition that produced the sum.
*/
`timescale 1ns/1ps
`default_nettype none
module mis_bcd_adj
  import mis_pkg::*;
(
  mis_bcd_if.unit bcd
);

  logic [DATA_W:0] wide;
  logic [DATA_W:0] step;
  logic            high_fix;

  always_comb begin
    wide     = {1'b0, bcd.acc};
    step     = wide;
    if ((bcd.acc[3:0] > NIB_MAX) || bcd.half) begin
      step = wide + LOW_FIX;
    end
    // Upper test uses the uncorrected sum, as the low fix can only carry out of bit 7 when the sum already was past 0x99
    high_fix = bcd.carry || (wide > BYTE_MAX) || step[DATA_W];
    if (high_fix) begin
      step = step + HIGH_FIX;
    end
    bcd.adj       = step[DATA_W-1:0];
    bcd.carry_adj = high_fix;
  end

endmodule : mis_bcd_adj
`default_nettype wire

// File: rtl/mis_exec.sv
/*
  Execution of decimal adjust, decrement-skip-zero, global interrupt on/off,
  absolute branch and the addition that feeds the adjust.
  Assumes the fetch logic offers one decoded instruction per cycle, holds it
  while busy_o is high, and that file_rdata_i is the register file's
  combinational read of file_addr_i on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mis_exec
  import mis_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                instr_valid_i,
  input  wire mis_op_type          op_i,
  input  wire logic [ADDR_W-1:0]   file_addr_i,
  input  wire logic                dest_i,
  input  wire logic [IMM_W-1:0]    imm_i,
  input  wire logic [DATA_W-1:0]   file_rdata_i,
  input  wire logic [PAGE_W-1:0]   page_high_buffer_i,
  output logic      [DATA_W-1:0]   acc_o,
  output logic                     carry_o,
  output logic                     zero_o,
  output logic                     global_interrupt_enable_o,
  output logic      [PC_W-1:0]     pc_o,
  output logic                     busy_o,
  output logic                     discard_o,
  output logic                     file_we_o,
  output logic      [ADDR_W-1:0]   file_waddr_o,
  output logic      [DATA_W-1:0]   file_wdata_o
);

  mis_state_type     state_q, state_d;
  logic [DATA_W-1:0] acc_q, acc_d;
  logic              carry_q, carry_d;
  logic              half_q, half_d;
  logic              zero_q, zero_d;
  logic              gie_q, gie_d;
  logic [PC_W-1:0]   pc_q, pc_d;
  logic              discard_q, discard_d;
  logic              we_q, we_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic              take;
  logic [DATA_W-1:0] dec_val;
  logic [DATA_W:0]   sum_val;
  logic [4:0]        nib_sum;

  mis_bcd_if bcd ();

  mis_bcd_adj u_adj (
    .bcd (bcd.unit)
  );

  assign bcd.acc   = acc_q;
  assign bcd.carry = carry_q;
  assign bcd.half  = half_q;

  assign take    = instr_valid_i && (state_q == ST_RUN);
  assign dec_val = file_rdata_i - DEC_STEP;
  assign sum_val = {1'b0, acc_q} + {1'b0, file_rdata_i};
  assign nib_sum = {1'b0, acc_q[3:0]} + {1'b0, file_rdata_i[3:0]};

  always_comb begin
    state_d   = ST_RUN;
    acc_d     = acc_q;
    carry_d   = carry_q;
    half_d    = half_q;
    zero_d    = zero_q;
    gie_d     = gie_q;
    pc_d      = pc_q;
    discard_d = 1'b0;
    we_d      = 1'b0;
    waddr_d   = waddr_q;
    wdata_d   = wdata_q;
    if (take) begin
      pc_d = pc_q + PC_STEP;
      case (op_i)
        OP_ADD: begin
          acc_d   = sum_val[DATA_W-1:0];
          carry_d = sum_val[DATA_W];
          half_d  = nib_sum[4];
          zero_d  = (sum_val[DATA_W-1:0] == ACC_RESET);
        end
        OP_DEC_ADJ: begin
          acc_d   = bcd.adj;
          carry_d = bcd.carry_adj;
        end
        OP_DEC_SKZ: begin
          zero_d = (dec_val == ACC_RESET);
          if (dest_i) begin
            we_d    = 1'b1;
            waddr_d = file_addr_i;
            wdata_d = dec_val;
          end else begin
            acc_d = dec_val;
          end
          if (dec_val == ACC_RESET) begin
            // Jump over the slot of the fetched instruction, which becomes a no-op
            pc_d      = pc_q + PC_SKIP;
            discard_d = 1'b1;
            state_d   = ST_FLUSH;
          end
        end
        OP_DIS_INT: begin
          gie_d = 1'b0;
        end
        OP_ENA_INT: begin
          gie_d = 1'b1;
        end
        OP_BRANCH: begin
          pc_d    = {page_high_buffer_i[PAGE_HI:PAGE_LO], imm_i};
          state_d = ST_FLUSH;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_q   <= ST_RUN;
      acc_q     <= ACC_RESET;
      carry_q   <= 1'b0;
      half_q    <= 1'b0;
      zero_q    <= 1'b0;
      gie_q     <= GIE_RESET;
      pc_q      <= PC_RESET;
      discard_q <= 1'b0;
      we_q      <= 1'b0;
      waddr_q   <= '0;
      wdata_q   <= ACC_RESET;
    end else begin
      state_q   <= state_d;
      acc_q     <= acc_d;
      carry_q   <= carry_d;
      half_q    <= half_d;
      zero_q    <= zero_d;
      gie_q     <= gie_d;
      pc_q      <= pc_d;
      discard_q <= discard_d;
      we_q      <= we_d;
      waddr_q   <= waddr_d;
      wdata_q   <= wdata_d;
    end
  end

  assign acc_o                     = acc_q;
  assign carry_o                   = carry_q;
  assign zero_o                    = zero_q;
  assign global_interrupt_enable_o = gie_q;
  assign pc_o                      = pc_q;
  assign busy_o                    = (state_q == ST_FLUSH);
  assign discard_o                 = discard_q;
  assign file_we_o                 = we_q;
  assign file_waddr_o              = waddr_q;
  assign file_wdata_o              = wdata_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  logic take_daa, take_dsz, take_dis, take_br;
  assign take_daa = take && (op_i == OP_DEC_ADJ);
  assign take_dsz = take && (op_i == OP_DEC_SKZ);
  assign take_dis = take && (op_i == OP_DIS_INT);
  assign take_br  = take && (op_i == OP_BRANCH);

  property p_daa_keep;
    take_daa && (acc_o[3:0] <= 4'h9) && (acc_o[7:4] <= 4'h9) && !carry_o && !half_q
      |=> (acc_o == $past(acc_o)) && !carry_o && (zero_o == $past(zero_o));
  endproperty
  a_daa_keep: assert property (p_daa_keep) else $error("adjust altered a valid decimal value");

  property p_daa_low;
    take_daa && (acc_o[3:0] > 4'h9) && (acc_o[7:4] < 4'h9) && !carry_o
      |=> (acc_o[3:0] == $past(acc_o[3:0]) + 4'h6) && (acc_o[7:4] == $past(acc_o[7:4]) + 4'h1) && !carry_o;
  endproperty
  a_daa_low: assert property (p_daa_low) else $error("low nibble correction wrong");

  property p_daa_carry;
    take_daa && (carry_o || (acc_o > 8'h99)) |=> carry_o;
  endproperty
  a_daa_carry: assert property (p_daa_carry) else $error("upper correction did not set carry");

  property p_dsz_reg;
    take_dsz && dest_i |=> file_we_o && (file_waddr_o == $past(file_addr_i))
      && (file_wdata_o == $past(file_rdata_i) - 8'h01) && (acc_o == $past(acc_o));
  endproperty
  a_dsz_reg: assert property (p_dsz_reg) else $error("decrement to register wrong");

  property p_dsz_acc;
    take_dsz && !dest_i |=> !file_we_o && (acc_o == $past(file_rdata_i) - 8'h01);
  endproperty
  a_dsz_acc: assert property (p_dsz_acc) else $error("decrement to accumulator wrong");

  property p_dsz_skip;
    take_dsz && (file_rdata_i == 8'h01)
      |=> discard_o && busy_o && (pc_o == $past(pc_o) + 11'h002) ##1 !discard_o && !busy_o;
  endproperty
  a_dsz_skip: assert property (p_dsz_skip) else $error("skip slot not discarded for one cycle");

  property p_dsz_one;
    take_dsz && (file_rdata_i != 8'h01) |=> !busy_o && !discard_o && (pc_o == $past(pc_o) + 11'h001);
  endproperty
  a_dsz_one: assert property (p_dsz_one) else $error("nonzero decrement took two cycles");

  property p_disable_interrupts;
    take_dis |=> !global_interrupt_enable_o && $stable(carry_o) && $stable(zero_o) && !busy_o;
  endproperty
  a_disable_interrupts: assert property (p_disable_interrupts) else $error("interrupt disable wrong");

  property p_branch_time;
    take_br |=> busy_o && $stable(carry_o) && $stable(zero_o) ##1 !busy_o && $stable(pc_o);
  endproperty
  a_branch_time: assert property (p_branch_time) else $error("branch not two cycles");

  property p_branch_target;
    take_br |=> pc_o == {$past(page_high_buffer_i[2:1]), $past(imm_i)};
  endproperty
  a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

endmodule : mis_exec
`default_nettype wire

// File: sim/mcu_instruction_subset_test.sv
/*
  Self-checking bench for the instruction subset execution block.
  Assumes mis_exec alone; the bench acts as fetch logic and register file.
*/
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_subset_test
  import mis_pkg::*;
;
  typedef struct {
    logic [7:0]  acc;
    logic        c;
    logic        hc;
    logic        z;
    logic        zk;
    logic        g;
    logic [10:0] pc;
    logic        we;
    logic [6:0]  wa;
    logic [7:0]  wd;
    logic        bz;
    logic        sk;
    int          due;
  } mis_note_type;

  logic              ref_clk_i;
  logic              resetn_i           = 1'b0;
  logic              instr_valid_i      = 1'b0;
  mis_op_type        op_i               = OP_NOP;
  logic [ADDR_W-1:0] file_addr_i        = '0;
  logic              dest_i             = 1'b0;
  logic [IMM_W-1:0]  imm_i              = '0;
  logic [DATA_W-1:0] file_rdata_i       = '0;
  logic [PAGE_W-1:0] page_high_buffer_i = '0;
  logic [DATA_W-1:0] acc_o;
  logic              carry_o, zero_o, global_interrupt_enable_o, busy_o, discard_o, file_we_o;
  logic [PC_W-1:0]   pc_o;
  logic [ADDR_W-1:0] file_waddr_o;
  logic [DATA_W-1:0] file_wdata_o;

  mis_note_type q[$];
  mis_note_type m = '{acc: 8'h00, c: 1'b0, hc: 1'b0, z: 1'b0, zk: 1'b1, g: 1'b0, pc: 11'h000,
                      we: 1'b0, wa: 7'h00, wd: 8'h00, bz: 1'b0, sk: 1'b0, due: 0};
  mis_note_type e;
  int           cyc        = 0;
  int           n_mismatch = 0;
  int           n_checks   = 0;
  logic         hold       = 1'b0;
  logic [7:0]   r;

  mis_exec u_mis_exec (
    .ref_clk_i, .resetn_i, .instr_valid_i, .op_i, .file_addr_i, .dest_i, .imm_i, .file_rdata_i,
    .page_high_buffer_i, .acc_o, .carry_o, .zero_o, .global_interrupt_enable_o, .pc_o, .busy_o,
    .discard_o, .file_we_o, .file_waddr_o, .file_wdata_o
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) cyc <= cyc + 1;

  task automatic conclude();
    if (q.size() > 0) n_mismatch++;
    if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Reference model; a note is due one cycle after the instruction is offered, one more if held
  task automatic issue(input mis_op_type op, input logic [6:0] a, input logic d,
                       input logic [8:0] im, input logic [7:0] rd, input logic [2:0] pg);
    logic [8:0] t;
    @(negedge ref_clk_i);
    instr_valid_i      = 1'b1;
    op_i               = op;
    file_addr_i        = a;
    dest_i             = d;
    imm_i              = im;
    file_rdata_i       = rd;
    page_high_buffer_i = pg;
    m.pc = m.pc + PC_STEP;
    m.we = 1'b0;
    m.bz = 1'b0;
    m.sk = 1'b0;
    t    = {1'b0, m.acc};
    case (op)
      OP_ADD: begin
        m.hc  = ({1'b0, m.acc[3:0]} + {1'b0, rd[3:0]}) > 5'h0f;
        t     = t + {1'b0, rd};
        m.c   = t[8];
        m.acc = t[7:0];
        m.z   = t[7:0] == 8'h00;
        m.zk  = 1'b1;
      end
      OP_DEC_ADJ: begin
        if (m.acc[3:0] > 4'h9 || m.hc) t = t + 9'h006;
        m.c = m.c || m.acc > 8'h99 || t[8];
        if (m.c) t = t + 9'h060;
        m.acc = t[7:0];
      end
      OP_DEC_SKZ: begin
        t    = {1'b0, rd - 8'h01};
        m.z  = t[7:0] == 8'h00;
        m.zk = 1'b1;
        m.we = d;
        m.wa = a;
        m.wd = t[7:0];
        if (!d) m.acc = t[7:0];
        m.sk = m.z;
        m.bz = m.z;
        if (m.z) m.pc = m.pc + PC_STEP;
      end
      OP_DIS_INT: m.g = 1'b0;
      OP_ENA_INT: m.g = 1'b1;
      OP_BRANCH: begin
        m.pc = {pg[2:1], im};
        m.bz = 1'b1;
      end
      default: ;
    endcase
    m.due = cyc + 1 + int'(hold);
    q.push_back(m);
    // Held through the busy slot: a second take would show up as a pc error
    repeat (1 + int'(hold)) @(posedge ref_clk_i);
    hold = m.bz;
  endtask : issue

  always @(negedge ref_clk_i) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      e = q.pop_front();
      chk("acc", acc_o, e.acc);
      chk("carry", carry_o, e.c);
      if (e.zk) chk("zero", zero_o, e.z);
      chk("interrupt_enable", global_interrupt_enable_o, e.g);
      chk("pc", pc_o, e.pc);
      chk("busy", busy_o, e.bz);
      chk("discard", discard_o, e.sk);
      chk("file_we", file_we_o, e.we);
      if (e.we) chk("file_write", {file_waddr_o, file_wdata_o}, {e.wa, e.wd});
    end
    if (cyc > 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    void'($urandom(30));
    repeat (3) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    resetn_i = 1'b1;
    issue(OP_ENA_INT, '0, 1'b0, '0, '0, '0);
    // Interrupts stay off from the addition until the adjust is done
    issue(OP_DIS_INT, '0, 1'b0, '0, '0, '0);
    issue(OP_ADD, 7'h05, 1'b0, '0, 8'h28, '0);
    issue(OP_ADD, 7'h05, 1'b0, '0, 8'h25, '0);
    issue(OP_DEC_ADJ, '0, 1'b0, '0, '0, '0);
    issue(OP_ENA_INT, '0, 1'b0, '0, '0, '0);
    issue(OP_DIS_INT, '0, 1'b0, '0, '0, '0);
    issue(OP_DEC_SKZ, 7'h7f, 1'b1, '0, 8'h01, '0);
    issue(OP_DEC_SKZ, 7'h00, 1'b0, '0, 8'h05, '0);
    issue(OP_DEC_SKZ, 7'h00, 1'b1, '0, 8'h00, '0);
    issue(OP_BRANCH, '0, 1'b0, 9'h1ff, '0, 3'h7);
    issue(OP_BRANCH, '0, 1'b0, 9'h000, '0, 3'h2);
    for (int i = 0; i < 200; i++) begin
      r = ($urandom_range(2) == 0) ? 8'h01 : 8'($urandom);
      case ($urandom_range(5))
        0: issue(OP_DEC_SKZ, 7'($urandom), 1'($urandom), '0, r, '0);
        1: issue(OP_BRANCH, '0, 1'b0, 9'($urandom), '0, 3'($urandom));
        2: begin
          issue(OP_DIS_INT, '0, 1'b0, '0, '0, '0);
          issue(OP_ADD, 7'($urandom), 1'b0, '0, r, '0);
          issue(OP_DEC_ADJ, '0, 1'b0, '0, '0, '0);
          issue(OP_ENA_INT, '0, 1'b0, '0, '0, '0);
        end
        3: issue(OP_DIS_INT, '0, 1'b0, '0, '0, '0);
        4: issue(OP_ENA_INT, '0, 1'b0, '0, '0, '0);
        default: issue(OP_NOP, '0, 1'b0, '0, '0, '0);
      endcase
    end
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    conclude();
  end
endmodule : mcu_instruction_subset_test
`default_nettype wire
